// ---- inc/irq_ctrl_regs.svh ----
// register offsets, field positions, reset values and vectors of the interrupt controller
// assumes a byte-addressed apb slave with one aligned 32-bit word per register
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_IRQ_FLAG_REGISTER_0 8'h00
`define OFF_IRQ_FLAG_REGISTER_1 8'h04
`define OFF_IRQ_FLAG_REGISTER_2 8'h08
`define OFF_IRQ_MASK_REGISTER_1 8'h0C
`define OFF_IRQ_MASK_REGISTER_2 8'h10
`define OFF_CORE_STATUS         8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LOW_GROUP_WIDTH         8
`define HIGH_GROUP_WIDTH        7
`define INPUT_CHANGE_FLAG_BIT   0
`define INPUT_CHANGE_MASK_BIT   7
`define STATUS_GLOBAL_BIT       0
`define STATUS_IN_SERVICE_BIT   1
`define STATUS_LAST_SRC_LSB     4
`define STATUS_LAST_SRC_MSB     7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MASK_RESET              15'h0000
`define GLOBAL_ENABLE_RESET     1'b0

// ----------------------------------------------------------------
// vector addresses, index 0 is reset, 15 is the lowest priority
// ----------------------------------------------------------------
`define VEC_0  16'h0000
`define VEC_1  16'h0003
`define VEC_2  16'h0006
`define VEC_3  16'h0009
`define VEC_4  16'h000F
`define VEC_5  16'h0012
`define VEC_6  16'h0015
`define VEC_7  16'h0018
`define VEC_8  16'h001B
`define VEC_9  16'h0021
`define VEC_10 16'h0024
`define VEC_11 16'h0027
`define VEC_12 16'h002A
`define VEC_13 16'h0030
`define VEC_14 16'h0033
`define VEC_15 16'h0036

`endif

// ---- inc/irq_ctrl_pkg.sv ----
// types shared by the interrupt controller files
// assumes nothing beyond a systemverilog compiler
package irq_ctrl_pkg;

	localparam int NSRC = 15;

	typedef struct packed {
		logic flag;
	} flag_state_t;

	typedef struct packed {
		logic [NSRC-1:0] mask;
		logic            ic_mask;
		logic            global_en;
		logic            in_service;
		logic            redirect;
		logic [15:0]     vec;
		logic [15:0]     ret;
		logic [3:0]      last_src;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic            irq;
	} ctrl_state_t;

endpackage

// ---- hw/flag_bit.sv ----
// one sticky interrupt flag: set by a hardware event, cleared by software
// assumes set and clear are synchronous to pclk; set wins over clear
module flag_bit (
	input  wire logic pclk,     // clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic ce,       // clock enable
	input  wire logic set_evt,  // event pulse or level
	input  wire logic clr,      // write-one-to-clear strobe
	output logic      flag_q    // sticky flag
);

	irq_ctrl_pkg::flag_state_t q;
	irq_ctrl_pkg::flag_state_t d;

	always_comb begin
		d = q;
		if (clr)
			d.flag = 1'b0;
		// an event in the clearing cycle must not be lost
		if (set_evt)
			d.flag = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign flag_q = q.flag;

endmodule

// ---- hw/vectored_interrupt_controller.sv ----
// vectored interrupt controller: sticky flags, masks, global enable, fetch redirect
// assumes the core pulses its instruction strobes for one cycle while ce is high
// and loads redirect/vector_addr into its fetch address on the following edge
`include "irq_ctrl_regs.svh"

module vectored_interrupt_controller #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,                              // clock, 20 MHz
	input  wire logic              presetn,                           // async reset, active low
	input  wire logic              ce,                                // clock enable
	input  wire logic              psel,                              // apb select
	input  wire logic              penable,                           // apb enable
	input  wire logic              pwrite,                            // apb direction
	input  wire logic [7:0]        paddr,                             // apb byte address
	input  wire logic [31:0]       pwdata,                            // apb write data
	output logic      [31:0]       prdata,                            // apb read data
	output logic                   pready,                            // apb ready
	output logic                   pslverr,                           // apb error
	input  wire logic [14:0]       src_event,                         // source events, bit0 = rank 1
	input  wire logic              input_change_event,                // pin input-change event
	input  wire logic              global_irq_on_instruction,         // enable-interrupts executed
	input  wire logic              global_irq_off_instruction,        // disable-interrupts executed
	input  wire logic              return_from_service_instruction,   // return-from-interrupt executed
	input  wire logic [ADDR_W-1:0] next_pc,                           // sequential fetch address
	output logic                   redirect,                          // fetch from vector_addr
	output logic      [ADDR_W-1:0] vector_addr,                       // vector to fetch from
	output logic      [ADDR_W-1:0] return_addr,                       // saved return address
	output logic                   global_enable,                     // global interrupt enable
	output logic                   irq                                // any unmasked flag set
);

	localparam int NSRC = irq_ctrl_pkg::NSRC;
	localparam int LOW  = `LOW_GROUP_WIDTH;
	localparam int HIGH = `HIGH_GROUP_WIDTH;

	// ----------------------------------------------------------------
	// vector table
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_TAB [16] = '{
		`VEC_0,  `VEC_1,  `VEC_2,  `VEC_3,  `VEC_4,  `VEC_5,  `VEC_6,  `VEC_7,
		`VEC_8,  `VEC_9,  `VEC_10, `VEC_11, `VEC_12, `VEC_13, `VEC_14, `VEC_15
	};

	irq_ctrl_pkg::ctrl_state_t q;
	irq_ctrl_pkg::ctrl_state_t d;

	logic [NSRC:0]   set_all;
	logic [NSRC:0]   clr_all;
	logic [NSRC:0]   flag_all;
	logic [NSRC-1:0] flags;
	logic            ic_flag;
	logic [NSRC-1:0] pending;
	logic [NSRC-1:0] eligible;
	logic [3:0]      sel;
	logic            setup;
	logic            wr_done;
	logic            mapped;
	logic [31:0]     rd_word;

	// lowest index wins; scan downward so the last hit is the winner
	function automatic logic [3:0] pick(input logic [NSRC-1:0] r);
		logic [3:0] s;
		s = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (r[i])
				s = 4'(i);
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// sticky flags
	// ----------------------------------------------------------------
	// the input-change flag only latches while its own mask allows it
	assign set_all = {input_change_event & q.ic_mask, src_event};

	for (genvar i = 0; i <= NSRC; i++) begin : g_flag
		flag_bit u_flag (
			.pclk    (pclk),
			.presetn (presetn),
			.ce      (ce),
			.set_evt (set_all[i]),
			.clr     (clr_all[i]),
			.flag_q  (flag_all[i])
		);
	end

	assign flags   = flag_all[NSRC-1:0];
	assign ic_flag = flag_all[NSRC];

	// ----------------------------------------------------------------
	// request selection
	// ----------------------------------------------------------------
	assign pending  = flags & q.mask;
	// the watchdog source (rank 1) is gated by its own enable only
	assign eligible = pending & {{(NSRC-1){q.global_en}}, 1'b1};
	assign sel      = pick(eligible);

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign setup   = psel & ~penable;
	assign wr_done = psel & penable & q.pready & pwrite & ~q.pslverr;

	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (paddr)
			`OFF_IRQ_FLAG_REGISTER_0:
				rd_word[LOW-1:0] = flags[LOW-1:0];
			`OFF_IRQ_FLAG_REGISTER_1:
				rd_word[HIGH-1:0] = flags[NSRC-1:LOW];
			`OFF_IRQ_FLAG_REGISTER_2:
				rd_word[`INPUT_CHANGE_FLAG_BIT] = ic_flag;
			`OFF_IRQ_MASK_REGISTER_1:
				rd_word[LOW-1:0] = q.mask[LOW-1:0];
			`OFF_IRQ_MASK_REGISTER_2: begin
				rd_word[HIGH-1:0]               = q.mask[NSRC-1:LOW];
				rd_word[`INPUT_CHANGE_MASK_BIT] = q.ic_mask;
			end
			`OFF_CORE_STATUS: begin
				rd_word[`STATUS_GLOBAL_BIT]                         = q.global_en;
				rd_word[`STATUS_IN_SERVICE_BIT]                     = q.in_service;
				rd_word[`STATUS_LAST_SRC_MSB:`STATUS_LAST_SRC_LSB] = q.last_src;
			end
			default:
				mapped = 1'b0;
		endcase
	end

	// write-one-to-clear strobes for the flag registers
	always_comb begin
		clr_all = '0;
		if (wr_done) begin
			unique case (paddr)
				`OFF_IRQ_FLAG_REGISTER_0:
					clr_all[LOW-1:0] = pwdata[LOW-1:0];
				`OFF_IRQ_FLAG_REGISTER_1:
					clr_all[NSRC-1:LOW] = pwdata[HIGH-1:0];
				`OFF_IRQ_FLAG_REGISTER_2:
					clr_all[NSRC] = pwdata[`INPUT_CHANGE_FLAG_BIT];
				default:
					clr_all = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;

		// one-cycle access phase: ready and data are set up in the setup cycle
		d.pready  = setup;
		d.pslverr = setup & ~mapped;
		if (setup)
			d.prdata = rd_word;

		if (wr_done) begin
			unique case (paddr)
				`OFF_IRQ_MASK_REGISTER_1:
					d.mask[LOW-1:0] = pwdata[LOW-1:0];
				`OFF_IRQ_MASK_REGISTER_2: begin
					d.mask[NSRC-1:LOW] = pwdata[HIGH-1:0];
					d.ic_mask          = pwdata[`INPUT_CHANGE_MASK_BIT];
				end
				default:
					d.mask = q.mask;
			endcase
		end

		if (global_irq_off_instruction)
			d.global_en = 1'b0;
		if (global_irq_on_instruction)
			d.global_en = 1'b1;
		if (return_from_service_instruction) begin
			d.global_en  = 1'b1;
			d.in_service = 1'b0;
		end

		// redirect is a single-cycle pulse; no new take while one is outstanding
		d.redirect = 1'b0;
		if ((|eligible) && !q.redirect) begin
			d.redirect   = 1'b1;
			d.vec        = VEC_TAB[4'(sel + 4'h1)];
			d.ret        = 16'(next_pc);
			d.global_en  = 1'b0;
			d.in_service = 1'b1;
			d.last_src   = 4'(sel + 4'h1);
		end

		d.irq = (|pending) | (ic_flag & q.ic_mask);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset leaves a redirect to vector 0 pending so the core starts there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q            <= '0;
			q.mask       <= `MASK_RESET;
			q.global_en  <= `GLOBAL_ENABLE_RESET;
			q.redirect   <= 1'b1;
			q.vec        <= `VEC_0;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign redirect      = q.redirect;
	assign vector_addr   = q.vec[ADDR_W-1:0];
	assign return_addr   = q.ret[ADDR_W-1:0];
	assign global_enable = q.global_en;
	assign irq           = q.irq;

endmodule

// ---- tb/vic_asserts.sv ----
// checker for the interrupt controller: take, enable and apb answer timing
// assumes the header macros and one pclk domain with async active-low reset
`include "irq_ctrl_regs.svh"
module vic_asserts #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,           // clock
	input wire logic              presetn,        // reset
	input wire logic              ce,             // clock enable
	input wire logic              psel,           // apb select
	input wire logic              penable,        // apb enable
	input wire logic              pready,         // apb ready
	input wire logic              pslverr,        // apb error
	input wire logic              global_irq_on_instruction,       // on strobe
	input wire logic              global_irq_off_instruction,      // off strobe
	input wire logic              return_from_service_instruction, // return strobe
	input wire logic [ADDR_W-1:0] next_pc,        // sequential address
	input wire logic              redirect,       // fetch redirect
	input wire logic [ADDR_W-1:0] vector_addr,    // vector
	input wire logic [ADDR_W-1:0] return_addr,    // saved address
	input wire logic              global_enable   // global enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	take_drops_ge_a: assert property (redirect |-> !global_enable)
		else $error("enable kept across a take");
	ret_saved_a: assert property ($rose(redirect) |-> return_addr == $past(next_pc))
		else $error("return address not captured");
	on_sets_ge_a: assert property (ce && global_irq_on_instruction |=> global_enable || redirect)
		else $error("on strobe did not enable");
	off_clears_a: assert property (ce && global_irq_off_instruction && !global_irq_on_instruction
		&& !return_from_service_instruction |=> !global_enable)
		else $error("off strobe did not disable");
	ret_sets_ge_a: assert property (ce && return_from_service_instruction
		|=> global_enable || redirect)
		else $error("return did not enable");
	one_pulse_a: assert property (ce && redirect |=> !redirect)
		else $error("redirect longer than one cycle");
	gated_take_a: assert property ($rose(redirect) && vector_addr != ADDR_W'(`VEC_1)
		|-> $past(global_enable))
		else $error("maskable taken while disabled");
	ge_cause_a: assert property ($rose(global_enable) |-> $past(global_irq_on_instruction)
		|| $past(return_from_service_instruction))
		else $error("enable rose without cause");
	apb_answer_a: assert property (ce && psel && !penable |=> pready)
		else $error("no ready after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind vectored_interrupt_controller vic_asserts #(.ADDR_W(ADDR_W)) u_vic_asserts (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .next_pc(next_pc), .redirect(redirect),
	.global_irq_on_instruction(global_irq_on_instruction),
	.global_irq_off_instruction(global_irq_off_instruction),
	.return_from_service_instruction(return_from_service_instruction),
	.vector_addr(vector_addr), .return_addr(return_addr), .global_enable(global_enable));

// ---- tb/core_model.sv ----
// fetch side of the core: sequential address that jumps on a redirect
// assumes redirect is a one-cycle pulse from the controller
module core_model #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,         // clock
	input  wire logic              presetn,      // reset, active low
	input  wire logic              redirect,     // fetch from vector
	input  wire logic [ADDR_W-1:0] vector_addr,  // vector
	output logic      [ADDR_W-1:0] next_pc       // sequential address
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			next_pc <= '0;
		else if (redirect)
			next_pc <= vector_addr;
		else
			next_pc <= next_pc + ADDR_W'(1);
	end
endmodule

// ---- tb/vectored_interrupt_controller_bench.sv ----
// bench for the interrupt controller: apb tasks, core strobes, source events
// assumes the core model feeds next_pc and the checker is bound in
`include "irq_ctrl_regs.svh"
module vectored_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AW = 12;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [14:0]   src = 15'h0000;
	logic          ic = 1'b0;
	logic          ce = 1'b1;
	logic [2:0]    ins = 3'h0;
	logic [31:0]   prdata, rd;
	logic          pready, pslverr, err, redirect, ge, irq;
	logic [AW-1:0] pc, va, ra;
	int            num_errors = 0;
	int            tests_run = 0;
	logic [15:0]   vt [16] = '{`VEC_0, `VEC_1, `VEC_2, `VEC_3, `VEC_4, `VEC_5, `VEC_6,
		`VEC_7, `VEC_8, `VEC_9, `VEC_10, `VEC_11, `VEC_12, `VEC_13, `VEC_14, `VEC_15};

	always #25 pclk = ~pclk;

	vectored_interrupt_controller #(.ADDR_W(AW)) u_vectored_interrupt_controller (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_event(src), .input_change_event(ic),
		.global_irq_on_instruction(ins[2]), .global_irq_off_instruction(ins[1]),
		.return_from_service_instruction(ins[0]), .next_pc(pc), .redirect(redirect),
		.vector_addr(va), .return_addr(ra), .global_enable(ge), .irq(irq));
	core_model #(.ADDR_W(AW)) u_core_model (
		.pclk(pclk), .presetn(presetn), .redirect(redirect), .vector_addr(va), .next_pc(pc));

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	// request held from setup until pready is sampled high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic instr(logic [2:0] v);
		@(posedge pclk);
		ins <= v;
		@(posedge pclk);
		ins <= 3'h0;
		@(posedge pclk);
	endtask

	task automatic evt(logic [14:0] s);
		@(posedge pclk);
		src <= s;
		@(posedge pclk);
		src <= 15'h0000;
	endtask

	task automatic take(int r);
		int n;
		n = 0;
		while (redirect !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk("taken", 32'h1, 32'(redirect));
		chk("vector", 32'(vt[r][AW-1:0]), 32'(va));
		chk("enable at take", 32'h0, 32'(ge));
		// the core stepped once past the captured address at the take edge
		chk("return address", 32'(pc) - 32'h1, 32'(ra));
		apb(1'b0, 8'h14, 32'h0);
		chk("status", (32'(r) << 4) | 32'h2, rd);
	endtask

	// an event while ce is low must leave no flag behind
	task automatic s_hold();
		@(posedge pclk);
		ce <= 1'b0;
		evt(15'h0002);
		@(posedge pclk);
		ce <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk("frozen flag", 32'h0, rd);
	endtask

	// write one to clear the flag of rank r, then return
	task automatic done(int r);
		apb(1'b1, r > 8 ? 8'h04 : 8'h00, 32'h1 << ((r - 1) % 8));
		instr(3'h1);
		chk("enable after return", 32'h1, 32'(ge));
	endtask

	task automatic s_flags();
		evt(15'h7FFF);
		apb(1'b0, 8'h00, 32'h0);
		chk("flags 0", 32'hFF, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("flags 1", 32'h7F, rd);
		chk("irq masked", 32'h0, 32'(irq));
		chk("no take", 32'h0, 32'(redirect));
		apb(1'b1, 8'h00, 32'hFF);
		apb(1'b1, 8'h04, 32'h7F);
		apb(1'b0, 8'h04, 32'h0);
		chk("cleared", 32'h0, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		@(posedge pclk);
		ic <= 1'b1;
		@(posedge pclk);
		ic <= 1'b0;
		apb(1'b0, 8'h08, 32'h0);
		chk("change masked", 32'h0, rd);
		apb(1'b1, 8'h10, 32'h80);
		@(posedge pclk);
		ic <= 1'b1;
		@(posedge pclk);
		ic <= 1'b0;
		apb(1'b0, 8'h08, 32'h0);
		chk("change flag", 32'h1, rd);
		chk("irq change", 32'h1, 32'(irq));
		apb(1'b1, 8'h10, 32'h00);
		apb(1'b1, 8'h08, 32'h01);
	endtask

	task automatic s_vectors();
		apb(1'b1, 8'h0C, 32'hFF);
		apb(1'b1, 8'h10, 32'h7F);
		for (int r = 1; r < 16; r++) begin
			instr(3'h4);
			evt(15'h1 << (r - 1));
			take(r);
			done(r);
		end
	endtask

	task automatic s_prio();
		instr(3'h2);
		evt(15'h0810);
		repeat (4) @(posedge pclk);
		chk("held while off", 32'h0, 32'(redirect));
		instr(3'h4);
		take(5);
		instr(3'h1);
		take(5);
		done(5);
		take(12);
		done(12);
	endtask

	task automatic s_mask();
		apb(1'b1, 8'h0C, 32'hFB);
		evt(15'h0004);
		apb(1'b0, 8'h00, 32'h0);
		chk("masked flag", 32'h04, rd);
		chk("masked take", 32'h0, 32'(redirect));
		chk("masked irq", 32'h0, 32'(irq));
		apb(1'b1, 8'h0C, 32'hFF);
		take(3);
		done(3);
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		chk("reset redirect", 32'h1, 32'(redirect));
		chk("reset vector", 32'h0, 32'(va));
		presetn <= 1'b1;
		s_flags();
		s_hold();
		s_vectors();
		s_prio();
		s_mask();
		conclude();
	end

	// the tests need about 400 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		conclude();
	end
endmodule
